//--- logic/msm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module msm_mapper
	import msm_pkg::*;
#(
	parameter int UNITS    = 4,
	parameter int GROUP_W  = 2,
	parameter int ID_W     = 20,
	parameter int STREAM_W = 16,
	parameter int EVENT_W  = 16
) (
	input  wire logic                     ref_clk_in,
	input  wire logic                     rst_b_in,
	input  wire logic                     init_load_in,
	input  wire msm_pkg::msm_kind_t       port_kind_in,
	input  wire logic [GROUP_W-1:0]       port_group_in,
	input  wire logic [ID_W-1:0]          port_offset_in,
	input  wire logic [UNITS*GROUP_W-1:0] unit_group_in,
	input  wire msm_pkg::msm_disp_t       illegal_disp_in,
	input  wire logic [ID_W-1:0]          alias_id_in,
	input  wire logic                     wr_valid_in,
	output logic                          wr_ready_out,
	input  wire logic [$clog2(UNITS)-1:0] wr_unit_in,
	input  wire logic [STREAM_W-1:0]      wr_stream_in,
	input  wire logic [EVENT_W-1:0]       wr_event_in,
	output logic                          fwd_valid_out,
	input  wire logic                     fwd_ready_in,
	output logic [$clog2(UNITS)-1:0]      fwd_unit_out,
	output logic [GROUP_W-1:0]            fwd_group_out,
	output logic [ID_W-1:0]               fwd_id_out,
	output logic [EVENT_W-1:0]            fwd_event_out,
	output logic                          abort_out,
	output logic                          configured_out
);
	import msm_pkg::*;

	localparam int UIDX_W = $clog2(UNITS);

	initial begin
		// one-unit tables would give a zero-width unit index
		if (ID_W < STREAM_W || ID_W < MSM_REQUESTER_W + 1 || UNITS < 2 || GROUP_W < 1
			|| STREAM_W < MSM_REQUESTER_W)
			$error("msm_mapper: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic                     cfg;
		msm_kind_t                kind;
		logic [GROUP_W-1:0]       group;
		logic [ID_W-1:0]          offset;
		logic [UNITS*GROUP_W-1:0] units;
		msm_disp_t                disp;
		logic [ID_W-1:0]          alias_id;
		logic                     fvalid;
		logic [UIDX_W-1:0]        funit;
		logic [GROUP_W-1:0]       fgroup;
		logic [ID_W-1:0]          fid;
		logic [EVENT_W-1:0]       fevent;
		logic                     abort;
	} msm_state_t;

	msm_state_t s_q;
	msm_state_t s_d;

	logic [GROUP_W-1:0] tgt_group_w;
	logic               tgt_valid_w;
	logic [ID_W-1:0]    src_id_w;
	logic               legal_w;
	logic               take_w;

	msm_unit_lookup #(
		.UNITS   (UNITS),
		.GROUP_W (GROUP_W)
	) u_lookup (
		.unit_group_in  (s_q.units),
		.unit_idx_in    (wr_unit_in),
		.group_out      (tgt_group_w),
		.unit_valid_out (tgt_valid_w)
	);

	////////////////////////////////////////////////////////////////////////
	// identifier derivation; per-stream id for translated and bridge ports, one id per port otherwise; independent of target unit
	always_comb begin
		unique case (s_q.kind)
			MSM_KIND_TRANSLATED: src_id_w = ID_W'(wr_stream_in) + s_q.offset;
			MSM_KIND_BRIDGE: src_id_w = ID_W'(wr_stream_in[MSM_REQUESTER_W-1:0])
				+ ID_W'(s_q.offset << MSM_COMPLEX_SHIFT);
			MSM_KIND_FIXED: src_id_w = s_q.offset;
			MSM_KIND_UNTRUSTED: src_id_w = s_q.offset;
		endcase
	end

	// untrusted ports (dma engines, processing elements) are never legal
	assign legal_w = s_q.cfg && tgt_valid_w && (tgt_group_w == s_q.group)
		&& (s_q.kind != MSM_KIND_UNTRUSTED);

	// output slot stalls the source; illegal drops need no slot but share it for simplicity
	assign wr_ready_out = s_q.cfg && (!s_q.fvalid || fwd_ready_in);
	assign take_w       = wr_valid_in && wr_ready_out;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d       = s_q;
		s_d.abort = 1'b0;
		// tables load once only; later loads are ignored so mapping never moves
		if (init_load_in && !s_q.cfg) begin
			s_d.cfg      = 1'b1;
			s_d.kind     = port_kind_in;
			s_d.group    = port_group_in;
			s_d.offset   = port_offset_in;
			s_d.units    = unit_group_in;
			s_d.disp     = illegal_disp_in;
			s_d.alias_id = alias_id_in;
		end
		if (s_q.fvalid && fwd_ready_in)
			s_d.fvalid = 1'b0;
		if (take_w) begin
			s_d.funit  = wr_unit_in;
			s_d.fevent = wr_event_in;
			s_d.fgroup = s_q.group;
			if (legal_w) begin
				s_d.fvalid = 1'b1;
				s_d.fid    = src_id_w;
			end else begin
				unique case (s_q.disp)
					MSM_DISP_FORWARD, MSM_DISP_ALIAS: begin
						s_d.fvalid = tgt_valid_w;
						s_d.fgroup = tgt_group_w;
						s_d.fid    = s_q.alias_id;
					end
					MSM_DISP_DROP: s_d.fvalid = 1'b0;
					MSM_DISP_ABORT: begin
						s_d.fvalid = 1'b0;
						s_d.abort  = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fwd_valid_out  = s_q.fvalid;
	assign fwd_unit_out   = s_q.funit;
	assign fwd_group_out  = s_q.fgroup;
	assign fwd_id_out     = s_q.fid;
	assign fwd_event_out  = s_q.fevent;
	assign abort_out      = s_q.abort;
	assign configured_out = s_q.cfg;

	////////////////////////////////////////////////////////////////////////
	sequence seq_legal_take;
		take_w && legal_w;
	endsequence

	sequence seq_illegal_take;
		take_w && !legal_w;
	endsequence

	chk_legal_forward: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		seq_legal_take |=> fwd_valid_out && fwd_group_out == $past(s_q.group))
		else $error("legal write not forwarded");

	chk_legal_id: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(seq_legal_take and (s_q.kind == MSM_KIND_TRANSLATED))
		|=> fwd_id_out == ID_W'($past(wr_stream_in)) + $past(s_q.offset))
		else $error("translated id wrong");

	chk_bridge_id: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(seq_legal_take and (s_q.kind == MSM_KIND_BRIDGE))
		|=> fwd_id_out[MSM_REQUESTER_W-1:0] == $past(wr_stream_in[MSM_REQUESTER_W-1:0]))
		else $error("bridge id low bits wrong");

	chk_fixed_id: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(seq_legal_take and (s_q.kind == MSM_KIND_FIXED)) |=> fwd_id_out == $past(s_q.offset))
		else $error("fixed id wrong");

	chk_no_masquerade: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		seq_illegal_take |=> !fwd_valid_out || fwd_id_out == $past(s_q.alias_id))
		else $error("illegal write forwarded with real id");

	chk_untrusted_blocked: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		take_w && s_q.kind == MSM_KIND_UNTRUSTED
		|=> !fwd_valid_out || fwd_id_out == $past(s_q.alias_id))
		else $error("untrusted write treated as legal");

	chk_abort_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		// back-to-back aborted writes may keep the pulse up for the next take only
		(seq_illegal_take and (s_q.disp == MSM_DISP_ABORT)) |=> abort_out ##1
			(abort_out == $past(take_w && !legal_w && s_q.disp == MSM_DISP_ABORT)))
		else $error("abort not a single pulse");

	chk_config_static: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		configured_out |=> configured_out && $stable(s_q.group) && $stable(s_q.offset)
			&& $stable(s_q.units))
		else $error("mapping changed after init");

	chk_hold_stall: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		fwd_valid_out && !fwd_ready_in |=> fwd_valid_out && $stable(fwd_id_out))
		else $error("forward output lost under stall");
endmodule
`default_nettype wire

//--- common/msm_pkg.sv
`default_nettype none
package msm_pkg;
	// port kinds
	typedef enum logic [1:0] {
		MSM_KIND_TRANSLATED = 2'b00,
		MSM_KIND_FIXED      = 2'b01,
		MSM_KIND_BRIDGE     = 2'b10,
		MSM_KIND_UNTRUSTED  = 2'b11
	} msm_kind_t;

	// disposition of a write
	typedef enum logic [1:0] {
		MSM_DISP_FORWARD = 2'b00,
		MSM_DISP_DROP    = 2'b01,
		MSM_DISP_ABORT   = 2'b10,
		MSM_DISP_ALIAS   = 2'b11
	} msm_disp_t;

	localparam int          MSM_REQUESTER_W   = 16;
	localparam logic [31:0] MSM_COMPLEX_STEP  = 32'h0001_0000;
	localparam int          MSM_COMPLEX_SHIFT = 16;
endpackage
`default_nettype wire

//--- logic/msm_unit_lookup.sv
`timescale 1ns/1ps
`default_nettype none
// maps a target unit index to its group; one static group per unit
module msm_unit_lookup #(
	parameter int UNITS   = 4,
	parameter int GROUP_W = 2
) (
	input  wire logic [UNITS*GROUP_W-1:0] unit_group_in,
	input  wire logic [$clog2(UNITS)-1:0] unit_idx_in,
	output logic      [GROUP_W-1:0]       group_out,
	output logic                          unit_valid_out
);
	import msm_pkg::*;

	logic [GROUP_W-1:0] table_w [UNITS];

	genvar g;
	generate
		for (g = 0; g < UNITS; g++) begin : g_unit
			assign table_w[g] = unit_group_in[g*GROUP_W +: GROUP_W];
		end
	endgenerate

	always_comb begin
		unit_valid_out = 32'(unit_idx_in) < UNITS;
		group_out      = unit_valid_out ? table_w[unit_idx_in] : '0;
	end
endmodule
`default_nettype wire

//--- test/msm_its_model.sv
`timescale 1ns/1ps
`default_nettype none
// translation unit side: always ready, or ready every second cycle
module msm_its_model (
	input  wire logic ref_clk_in,
	input  wire logic rst_b_in,
	input  wire logic stall_in,
	output logic      fwd_ready_out
);
	logic tgl_q;
	// slow mode makes forwarded writes stand and blocks new takes
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) tgl_q <= 1'b0;
		else tgl_q <= ~tgl_q;
	end
	assign fwd_ready_out = !stall_in || tgl_q;
endmodule
`default_nettype wire

//--- test/msm_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msm_mapper_tb;
	import msm_pkg::*;
	logic        ref_clk_in = 0, rst_b_in = 0, init_load_in = 0, wr_valid_in = 0, stall = 0;
	msm_kind_t   kind = MSM_KIND_TRANSLATED;
	msm_disp_t   disp = MSM_DISP_ALIAS;
	logic [1:0]  grp = 0, wr_unit = 0, f_unit, f_grp;
	logic [19:0] off = 0, f_id;
	logic [15:0] strm = 0, f_ev;
	logic        wr_ready, fwd_valid, fwd_ready, abort, cfg;
	int          error_cnt = 0, tests_run = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	// units 0,1 in group 1, unit 2 in group 0, unit 3 in group 2
	msm_mapper dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .init_load_in(init_load_in),
		.port_kind_in(kind), .port_group_in(grp), .port_offset_in(off),
		.unit_group_in(8'h85), .illegal_disp_in(disp), .alias_id_in(20'hF_FFFF),
		.wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready), .wr_unit_in(wr_unit),
		.wr_stream_in(strm), .wr_event_in(~strm), .fwd_valid_out(fwd_valid),
		.fwd_ready_in(fwd_ready), .fwd_unit_out(f_unit), .fwd_group_out(f_grp),
		.fwd_id_out(f_id), .fwd_event_out(f_ev), .abort_out(abort), .configured_out(cfg));
	msm_its_model its (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .stall_in(stall),
		.fwd_ready_out(fwd_ready));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
		tests_run++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	task automatic ld(input msm_kind_t k, input logic [19:0] o, input msm_disp_t d);
		@(negedge ref_clk_in);
		rst_b_in = 0;
		kind = k;
		grp = 2'h1;
		off = o;
		disp = d;
		repeat (8) @(negedge ref_clk_in);
		rst_b_in = 1;
		@(negedge ref_clk_in);
		chk("ready_before_load", 40'h0, {39'h0, wr_ready});
		init_load_in = 1;
		@(negedge ref_clk_in);
		init_load_in = 0;
		chk("configured", 40'h1, {39'h0, cfg});
	endtask
	// one write; expected answer checked one cycle after it is taken
	task automatic wr(input logic [1:0] u, input logic [15:0] s, input logic v, ab,
			input logic [1:0] g, input logic [19:0] id);
		bit took;
		took = 0;
		@(negedge ref_clk_in);
		wr_valid_in = 1;
		wr_unit = u;
		strm = s;
		for (int i = 0; i < 20 && !took; i++) begin
			took = wr_ready;
			@(negedge ref_clk_in);
		end
		wr_valid_in = 0;
		if (!took) begin
			$display("mismatch write_taken expected 1 seen 0");
			error_cnt++;
			print_verdict();
		end
		chk("valid_abort", {38'h0, v, ab}, {38'h0, fwd_valid, abort});
		if (v) chk("fwd_fields", {g, id, u, ~s}, {f_grp, f_id, f_unit, f_ev});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_trans;
		ld(MSM_KIND_TRANSLATED, 20'h0_0010, MSM_DISP_ALIAS);
		stall = 1;
		wr(2'd0, 16'h0005, 1, 0, 2'd1, 20'h0_0015);
		wr(2'd1, 16'h0005, 1, 0, 2'd1, 20'h0_0015);
		wr(2'd1, 16'h0006, 1, 0, 2'd1, 20'h0_0016);
		wr(2'd2, 16'h0005, 1, 0, 2'd0, 20'hF_FFFF);
		stall = 0;
		grp = 2'h2;
		init_load_in = 1;
		@(negedge ref_clk_in);
		init_load_in = 0;
		wr(2'd0, 16'h0005, 1, 0, 2'd1, 20'h0_0015);
		$display("test translated done");
	endtask
	task automatic t_bridge;
		ld(MSM_KIND_BRIDGE, 20'h0_0003, MSM_DISP_DROP);
		wr(2'd0, 16'h1234, 1, 0, 2'd1, 20'h3_1234);
		wr(2'd3, 16'h1234, 0, 0, 2'd0, 20'h0_0000);
		$display("test bridge done");
	endtask
	task automatic t_fixed;
		ld(MSM_KIND_FIXED, 20'h0_0007, MSM_DISP_ABORT);
		wr(2'd1, 16'h0055, 1, 0, 2'd1, 20'h0_0007);
		wr(2'd2, 16'h0055, 0, 1, 2'd0, 20'h0_0000);
		ld(MSM_KIND_UNTRUSTED, 20'h0_0000, MSM_DISP_ABORT);
		wr(2'd0, 16'h0001, 0, 1, 2'd0, 20'h0_0000);
		ld(MSM_KIND_UNTRUSTED, 20'h0_0000, MSM_DISP_FORWARD);
		wr(2'd0, 16'h0001, 1, 0, 2'd1, 20'hF_FFFF);
		$display("test fixed and untrusted done");
	endtask
	initial begin
		t_trans();
		t_bridge();
		t_fixed();
		print_verdict();
	end
endmodule
`default_nettype wire
